// >>> pkg/crf_pkg.sv
// package: constants and carrier types for the cpu register file and status flags
package crf_pkg;
  localparam int NUM_REGS = 32;
  localparam int REG_W = 8;
  localparam int ADDR_W = 16;
  localparam int IO_REGS = 64;
  // data-space map
  localparam logic [15:0] DS_REG_BASE = 16'h0000;
  localparam logic [15:0] DS_IO_BASE = 16'h0020;
  localparam logic [15:0] DS_IO_LAST = 16'h005F;
  // pointer pairs: low register index of each pair
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  // status flag bit positions
  localparam int SF_C = 0;
  localparam int SF_Z = 1;
  localparam int SF_N = 2;
  localparam int SF_V = 3;
  localparam int SF_S = 4;
  localparam int SF_H = 5;
  localparam int SF_T = 6;
  localparam int SF_I = 7;
  localparam logic [7:0] SF_RESET = 8'h00;

  typedef enum logic [1:0] {
    CRF_PTR_X = 2'b00,
    CRF_PTR_Y = 2'b01,
    CRF_PTR_Z = 2'b10,
    CRF_PTR_NONE = 2'b11
  } crf_ptr_sel_t;

  typedef enum logic [1:0] {
    CRF_AM_PLAIN = 2'b00,
    CRF_AM_POSTINC = 2'b01,
    CRF_AM_PREDEC = 2'b10,
    CRF_AM_DISP = 2'b11
  } crf_addr_mode_t;

  typedef enum logic [2:0] {
    CRF_IE_NONE = 3'b000,
    CRF_IE_SET = 3'b001,
    CRF_IE_CLEAR = 3'b010,
    CRF_IE_RETURN = 3'b011,
    CRF_IE_TAKEN = 3'b100
  } crf_irq_op_t;

  // register-file access from the decoder
  typedef struct packed {
    logic [4:0] rd_a;
    logic [4:0] rd_b;
    logic wr8;
    logic wr16;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
  } crf_rf_req_t;

  // flag update from the alu
  typedef struct packed {
    logic [7:0] mask;
    logic c;
    logic z;
    logic n;
    logic v;
    logic h;
  } crf_flag_upd_t;

  // pointer addressing request
  typedef struct packed {
    crf_ptr_sel_t sel;
    crf_addr_mode_t mode;
    logic [5:0] disp;
  } crf_ptr_req_t;
endpackage

// >>> hw/crf_reg_array.sv
// 32 x 8 working register array, two 8-bit reads, 8- or 16-bit write
module crf_reg_array #(
  parameter int NREGS = 32,
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] rd_a,
  input wire logic [4:0] rd_b,
  input wire logic [4:0] rd_p,
  output logic [W-1:0] q_a,
  output logic [W-1:0] q_b,
  output logic [2*W-1:0] q_p,
  input wire logic we_lo,
  input wire logic [4:0] wa_lo,
  input wire logic [W-1:0] wd_lo,
  input wire logic we_hi,
  input wire logic [4:0] wa_hi,
  input wire logic [W-1:0] wd_hi
);
  logic [W-1:0] mem_q [NREGS];

  // reads are combinational so operands, alu and writeback fit one cycle
  assign q_a = mem_q[rd_a];
  assign q_b = mem_q[rd_b];
  assign q_p = {mem_q[rd_p + 5'd1], mem_q[rd_p]};

  genvar gi;
  generate
    for (gi = 0; gi < NREGS; gi++) begin : g_reg
      always_ff @(posedge mclk) begin
        if (rst) begin
          mem_q[gi] <= '0;
        end else if (we_hi && wa_hi == 5'(gi)) begin
          mem_q[gi] <= wd_hi;
        end else if (we_lo && wa_lo == 5'(gi)) begin
          mem_q[gi] <= wd_lo;
        end
      end
    end
  endgenerate
endmodule // crf_reg_array

// >>> hw/crf_core_state.sv
// cpu datapath state: register file, pointer pairs, data-space decode, status flags
// ---------------------------------------------------------------
// Overview of operation
// RL1 - fetch overlaps execute, one instruction per clock
// RL2 - 32 eight-bit registers, single-cycle access
// RL3 - read operands, compute, write back same cycle
// RL4 - register and immediate alu ops single cycle
// RL5 - four port shapes: 8/16-bit reads and writes
// RL6 - top six registers form pointers x, y, z
// RL7 - z pointer addresses program flash lookups
// RL8 - pointers support displacement, post-increment, pre-decrement
// RL9 - registers mapped to first 32 data addresses
// RL10 - io space at data addresses after registers
// RL11 - status flags updated after each alu op
// RL12 - no status save or restore on interrupts
// RL13 - global enable low blocks every interrupt
// RL14 - entry clears enable; return_from_interrupt and set_irq_enable set
// RL15 - bit copy flag loaded and stored by instructions
// RL16 - half carry flags low nibble carry
// RL17 - sign flag always negative xor overflow
// RL18 - bits three to zero: v n z c
// RL19 - return pc pushed to sram stack
// RL20 - lowest vector address wins priority
// RL21 - software initialises stack pointer before use
// RL22 - status flags reset to zero
// ---------------------------------------------------------------
module crf_core_state (
  input wire logic mclk,
  input wire logic rst,
  // register ports
  // operand ports are combinational so the alu result returns in the same cycle
  input wire crf_pkg::crf_rf_req_t rf_req,
  output logic [7:0] opnd_a,
  output logic [7:0] opnd_b,
  output logic [15:0] opnd_w,
  // pointer addressing
  input wire crf_pkg::crf_ptr_req_t ptr_req,
  output logic [15:0] ds_addr,
  output logic ds_is_reg,
  output logic ds_is_io,
  output logic [5:0] io_addr,
  output logic [15:0] flash_lookup_addr,
  // data-space write into the register file
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  // status flags
  input wire crf_pkg::crf_flag_upd_t flag_upd,
  input wire crf_pkg::crf_irq_op_t irq_op,
  input wire logic bit_store_instr,
  input wire logic [4:0] bit_reg,
  input wire logic [2:0] bit_pos,
  input wire logic bit_load_instr,
  input wire logic sf_wr,
  input wire logic [7:0] sf_wdata,
  input wire logic [7:0] irq_pending,
  output logic [7:0] status_flags,
  output logic irq_take,
  output logic [2:0] irq_vector
);
  import crf_pkg::*;

  // ---------------------------------------------------------------
  // pointer select and data-space address
  // ---------------------------------------------------------------
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ptr_upd;
  logic ptr_wr;
  logic [15:0] addr_d;

  // the none code never writes, so its default index only keeps the mux complete
  always_comb begin
    case (ptr_req.sel)
      CRF_PTR_X: ptr_lo = PTR_X_LO; // RL6
      CRF_PTR_Y: ptr_lo = PTR_Y_LO; // RL6
      CRF_PTR_Z: ptr_lo = PTR_Z_LO; // RL6
      default: ptr_lo = PTR_Z_LO;
    endcase
  end

  // predec addresses with the new value, postinc with the old one
  // with no pointer selected a mode only shapes the address, nothing is written
  always_comb begin
    ptr_upd = ptr_val;
    ptr_wr = 1'b0;
    addr_d = ptr_val;
    case (ptr_req.mode)
      CRF_AM_POSTINC: begin
        ptr_upd = ptr_val + 16'h0001; // RL8
        ptr_wr = (ptr_req.sel != CRF_PTR_NONE);
      end
      CRF_AM_PREDEC: begin
        ptr_upd = ptr_val - 16'h0001; // RL8
        addr_d = ptr_upd;
        ptr_wr = (ptr_req.sel != CRF_PTR_NONE);
      end
      CRF_AM_DISP: addr_d = ptr_val + {10'h000, ptr_req.disp}; // RL8
      default: addr_d = ptr_val;
    endcase
  end

  // ---------------------------------------------------------------
  // register array write arbitration
  // ---------------------------------------------------------------
  // a pointer update owns the 16-bit write path; an alu 16-bit result
  // in the same cycle is not expected from the decoder
  // low port priority: pointer, 16-bit result, bit load, 8-bit result,
  // then a store through a pointer; a store that loses is dropped
  logic ds_reg_hit;
  logic we_lo;
  logic we_hi;
  logic [4:0] wa_lo;
  logic [4:0] wa_hi;
  logic [7:0] wd_lo;
  logic [7:0] wd_hi;
  logic [7:0] bit_load_val;
  logic [7:0] sf_q;

  // only the bottom 32 data addresses land in the array
  assign ds_reg_hit = ds_wr && (addr_d < DS_IO_BASE); // RL9

  // bit load rewrites one bit of the register read on port a
  always_comb begin
    bit_load_val = opnd_a;
    bit_load_val[bit_pos] = sf_q[SF_T]; // RL15
  end

  always_comb begin
    we_lo = 1'b0;
    we_hi = 1'b0;
    wa_lo = rf_req.wr_addr;
    wa_hi = rf_req.wr_addr + 5'd1;
    wd_lo = rf_req.wr_data[7:0];
    wd_hi = rf_req.wr_data[15:8];
    if (ptr_wr) begin
      we_lo = 1'b1;
      we_hi = 1'b1;
      wa_lo = ptr_lo;
      wa_hi = ptr_lo + 5'd1;
      wd_lo = ptr_upd[7:0];
      wd_hi = ptr_upd[15:8];
    end else if (rf_req.wr16) begin
      we_lo = 1'b1; // RL5
      we_hi = 1'b1; // RL5
    end else if (bit_load_instr) begin
      we_lo = 1'b1;
      wa_lo = bit_reg;
      wd_lo = bit_load_val; // RL15
    end else if (rf_req.wr8) begin
      we_lo = 1'b1; // RL3
    end
    // a store through a pointer may land on a working register
    if (ds_reg_hit && !we_lo) begin
      we_lo = 1'b1; // RL9
      wa_lo = addr_d[4:0];
      wd_lo = ds_wdata;
    end
  end

  crf_reg_array #(
    .NREGS(NUM_REGS),
    .W(REG_W)
  ) u_array (
    .mclk(mclk),
    .rst(rst),
    .rd_a(bit_load_instr ? bit_reg : rf_req.rd_a),
    .rd_b(bit_store_instr ? bit_reg : rf_req.rd_b),
    .rd_p(ptr_req.sel == CRF_PTR_NONE ? rf_req.rd_a : ptr_lo),
    // operands need no wait state, so a new instruction can use them every clock
    .q_a(opnd_a), // RL1
    .q_b(opnd_b), // RL4
    .q_p(opnd_w),
    .we_lo(we_lo),
    .wa_lo(wa_lo),
    .wd_lo(wd_lo),
    .we_hi(we_hi),
    .wa_hi(wa_hi),
    .wd_hi(wd_hi)
  ); // RL2

  // the pointer value comes from the pair read port of the array
  assign ptr_val = opnd_w;

  // ---------------------------------------------------------------
  // registered address outputs
  // ---------------------------------------------------------------
  logic [15:0] ds_addr_q;
  logic ds_is_reg_q;
  logic ds_is_io_q;
  logic [5:0] io_addr_q;
  logic [15:0] flash_q;

  // above the io window neither flag is raised; io_addr_q is then meaningless

  always_ff @(posedge mclk) begin
    if (rst) begin
      ds_addr_q <= 16'h0000;
      ds_is_reg_q <= 1'b0;
      ds_is_io_q <= 1'b0;
      io_addr_q <= 6'h00;
    end else begin
      ds_addr_q <= addr_d;
      ds_is_reg_q <= (addr_d < DS_IO_BASE); // RL9
      ds_is_io_q <= (addr_d >= DS_IO_BASE) && (addr_d <= DS_IO_LAST); // RL10
      io_addr_q <= 6'(addr_d - DS_IO_BASE); // RL10
    end
  end

  // z pointer is always the flash lookup source, one cycle later
  // a z write and a z select in one cycle leave the old pointer here
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_q <= 16'h0000;
    end else if (ptr_req.sel == CRF_PTR_Z) begin
      flash_q <= ptr_val; // RL7
    end
  end

  // outputs wired straight from their flip-flops
  assign ds_addr = ds_addr_q;
  assign ds_is_reg = ds_is_reg_q;
  assign ds_is_io = ds_is_io_q;
  assign io_addr = io_addr_q;
  assign flash_lookup_addr = flash_q;

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic [7:0] sf_d;
  // the take decision is made further down but also clears the enable here
  logic irq_take_d;
  logic [2:0] vec_d;
  logic irq_take_q;
  logic [2:0] vec_q;

  // software write goes first, so an alu mask or irq op in the same cycle wins
  always_comb begin
    sf_d = sf_q;
    if (sf_wr) begin
      sf_d = sf_wdata;
    end
    // alu results land in the same cycle as the operation
    if (flag_upd.mask[SF_C]) sf_d[SF_C] = flag_upd.c; // RL18
    if (flag_upd.mask[SF_Z]) sf_d[SF_Z] = flag_upd.z; // RL18
    if (flag_upd.mask[SF_N]) sf_d[SF_N] = flag_upd.n; // RL18
    if (flag_upd.mask[SF_V]) sf_d[SF_V] = flag_upd.v; // RL18
    if (flag_upd.mask[SF_H]) sf_d[SF_H] = flag_upd.h; // RL16
    if (bit_store_instr) sf_d[SF_T] = opnd_b[bit_pos]; // RL15
    // the taken code changes nothing; the take below does the clearing
    case (irq_op)
      CRF_IE_SET: sf_d[SF_I] = 1'b1; // RL14
      CRF_IE_RETURN: sf_d[SF_I] = 1'b1; // RL14
      CRF_IE_CLEAR: sf_d[SF_I] = 1'b0; // RL14
      default: sf_d[SF_I] = sf_d[SF_I];
    endcase
    // taking an interrupt outranks any other source of the enable
    if (irq_take_d) sf_d[SF_I] = 1'b0; // RL14
    // the status byte is never pushed or popped here
    sf_d[SF_S] = sf_d[SF_N] ^ sf_d[SF_V]; // RL17 RL12
  end

  // reset leaves the enable low, so nothing is taken before software sets it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sf_q <= SF_RESET; // RL22
    end else begin
      sf_q <= sf_d; // RL11
    end
  end

  assign status_flags = sf_q;

  // ---------------------------------------------------------------
  // interrupt acceptance
  // ---------------------------------------------------------------
  // clear in the same cycle blocks acceptance, so no interrupt slips past it
  // a return from interrupt blocks it too: one more instruction runs first
  // scanning from the top leaves the lowest pending source as the vector

  always_comb begin
    vec_d = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (irq_pending[i]) vec_d = 3'(i); // RL20
    end
    irq_take_d = sf_q[SF_I] && (irq_pending != 8'h00) && !irq_take_q
                 && (irq_op != CRF_IE_CLEAR) && (irq_op != CRF_IE_RETURN); // RL13
  end

  // one-cycle pulse: the cycle after a take never takes again
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_take_q <= 1'b0;
      vec_q <= 3'd0;
    end else begin
      irq_take_q <= irq_take_d; // RL19
      vec_q <= vec_d;
    end
  end

  assign irq_take = irq_take_q;
  assign irq_vector = vec_q;
endmodule // crf_core_state

// >>> dv/crf_core_state_props.sv
// checker: timing properties of the core state ports
module crf_core_state_props import crf_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] opnd_w,
  input wire crf_ptr_req_t ptr_req,
  input wire logic [15:0] ds_addr,
  input wire logic ds_is_reg,
  input wire logic ds_is_io,
  input wire logic [5:0] io_addr,
  input wire crf_flag_upd_t flag_upd,
  input wire crf_irq_op_t irq_op,
  input wire logic sf_wr,
  input wire logic [7:0] irq_pending,
  input wire logic [7:0] status_flags,
  input wire logic irq_take,
  input wire logic [2:0] irq_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  function automatic logic [2:0] lo_bit(logic [7:0] p);
    for (int i = 7; i >= 0; i--) if (p[i]) lo_bit = i[2:0];
  endfunction
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_clear: assert property (disable iff (1'b0) rst |=> status_flags == SF_RESET)
    else $error("flags not cleared by reset");
  a_sign_xor: assert property (status_flags[SF_S] == (status_flags[SF_N] ^ status_flags[SF_V]))
    else $error("sign bit wrong");
  a_irq_gated: assert property (irq_take |-> $past(status_flags[SF_I]))
    else $error("interrupt taken while disabled");
  a_take_clears: assert property (irq_take |-> !status_flags[SF_I])
    else $error("enable kept on entry");
  a_take_prio: assert property (irq_take |-> irq_vector == lo_bit($past(irq_pending)))
    else $error("wrong vector chosen");
  a_cli_blocks: assert property (irq_op == CRF_IE_CLEAR |=> !status_flags[SF_I] && !irq_take)
    else $error("clear did not block");
  a_set_enables: assert property (irq_op == CRF_IE_SET && !sf_wr |=> status_flags[SF_I] || irq_take)
    else $error("set did not enable");
  a_flag_load: assert property (flag_upd.mask[SF_C] && flag_upd.mask[SF_Z] && !sf_wr |=>
    status_flags[SF_C] == $past(flag_upd.c) && status_flags[SF_Z] == $past(flag_upd.z))
    else $error("flags not updated");
  a_disp_addr: assert property (ptr_req.sel != CRF_PTR_NONE && ptr_req.mode == CRF_AM_DISP |=>
    ds_addr == $past(opnd_w) + 16'($past(ptr_req.disp))) else $error("displacement address wrong");
  a_io_decode: assert property (ds_is_io |-> ds_addr inside {[DS_IO_BASE:DS_IO_LAST]} &&
    io_addr == 6'(ds_addr - DS_IO_BASE)) else $error("io decode wrong");
  a_reg_decode: assert property (ds_is_reg |-> ds_addr < DS_IO_BASE)
    else $error("register decode wrong");
  c_take: cover property (irq_take);
  c_io: cover property (ds_is_io);
  c_half: cover property (flag_upd.mask[SF_H] && flag_upd.h);
endmodule // crf_core_state_props

bind crf_core_state crf_core_state_props u_props (.mclk, .rst, .opnd_w, .ptr_req, .ds_addr, .ds_is_reg,
  .ds_is_io, .io_addr, .flag_upd, .irq_op, .sf_wr, .irq_pending, .status_flags, .irq_take, .irq_vector);

// >>> dv/crf_alu_model.sv
// far-side model: alu adder giving result and flag update
module crf_alu_model import crf_pkg::*; (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] sum,
  output crf_flag_upd_t upd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] full;
  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    sum = full[7:0];
    // sign bit left out of the mask: the core derives it
    upd.mask = 8'h2f;
    upd.c = full[8];
    upd.z = full[7:0] == 8'h00;
    upd.n = full[7];
    upd.v = (a[7] == b[7]) && (full[7] != a[7]);
    upd.h = full[4] ^ a[4] ^ b[4];
  end
endmodule // crf_alu_model

// >>> dv/test_cpu_register_file_status.sv
// testbench: register file, pointers and status flags of the core
module test_cpu_register_file_status import crf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a, b, s, f;} crf_tb_row_t;
  crf_tb_row_t rows [5] = '{'{8'h0f, 8'h01, 8'h10, 8'h20}, '{8'hff, 8'h01, 8'h00, 8'h23},
    '{8'h7f, 8'h01, 8'h80, 8'h2c}, '{8'h80, 8'h80, 8'h00, 8'h1b}, '{8'h40, 8'h40, 8'h80, 8'h0c}};
  logic mclk, rst, alu_on, ds_wr, bit_store_instr, bit_load_instr, sf_wr, ds_is_reg, ds_is_io, irq_take;
  logic [7:0] ds_wdata, sf_wdata, irq_pending, status_flags, opnd_a, opnd_b, alu_sum;
  logic [4:0] bit_reg;
  logic [2:0] bit_pos, irq_vector;
  logic [15:0] opnd_w, ds_addr, flash_lookup_addr;
  logic [5:0] io_addr;
  crf_rf_req_t rf_req, req;
  crf_ptr_req_t ptr_req;
  crf_flag_upd_t flag_upd, alu_upd;
  crf_irq_op_t irq_op;
  int fail_count, n_checks;
  // the alu model answers in the same cycle as the operands appear
  assign rf_req = alu_on ? crf_rf_req_t'{5'd1, 5'd2, 1'b1, 1'b0, 5'd3, {8'h00, alu_sum}} : req;
  assign flag_upd = alu_on ? alu_upd : '0;
  crf_core_state dut (.mclk, .rst, .rf_req, .opnd_a, .opnd_b, .opnd_w, .ptr_req, .ds_addr, .ds_is_reg,
    .ds_is_io, .io_addr, .flash_lookup_addr, .ds_wr, .ds_wdata, .flag_upd, .irq_op, .bit_store_instr,
    .bit_reg, .bit_pos, .bit_load_instr, .sf_wr, .sf_wdata, .irq_pending, .status_flags, .irq_take, .irq_vector);
  crf_alu_model alu (.a(opnd_a), .b(opnd_b), .sum(alu_sum), .upd(alu_upd));
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  task chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc;
    @(posedge mclk);
    #10;
  endtask
  task wr(logic [4:0] a, logic [15:0] d, logic w);
    req = '{5'd0, 5'd0, !w, w, a, d};
    cyc();
  endtask
  task rdchk(logic [4:0] a, logic [7:0] exp);
    req = '{a, 5'd0, 1'b0, 1'b0, 5'd0, 16'h0000};
    #20;
    chk("reg", opnd_a, exp);
    cyc();
  endtask
  // generous bound: the sequence needs well under 200 cycles
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    rst = 1;
    {alu_on, ds_wr, ds_wdata, bit_store_instr, bit_reg, bit_pos, bit_load_instr, sf_wr, sf_wdata} = '0;
    req = '0;
    irq_pending = 8'h00;
    irq_op = CRF_IE_NONE;
    ptr_req = '{CRF_PTR_NONE, CRF_AM_PLAIN, 6'h00};
    repeat (10) cyc();
    rst = 0;
    for (int i = 0; i < 5; i++) begin
      wr(5'd1, {8'h00, rows[i].a}, 0);
      wr(5'd2, {8'h00, rows[i].b}, 0);
      alu_on = 1;
      #20 chk("alu opnd a", opnd_a, rows[i].a);
      chk("alu opnd b", opnd_b, rows[i].b);
      cyc();
      alu_on = 0;
      chk("flags", status_flags, rows[i].f);
      chk("half carry", status_flags[SF_H], rows[i].f[SF_H]);
      chk("low flags", status_flags[3:0], rows[i].f[3:0]);
      rdchk(5'd3, rows[i].s);
    end
    rst = 1;
    repeat (2) cyc();
    rst = 0;
    chk("reset flags", status_flags, SF_RESET);
    rdchk(5'd3, 8'h00);
    wr(PTR_X_LO, 16'h0005, 1);
    ptr_req = '{CRF_PTR_X, CRF_AM_POSTINC, 6'h00};
    req = '0;
    cyc();
    chk("postinc addr", ds_addr, 16'h0005);
    chk("reg hit", ds_is_reg, 1);
    ptr_req = '{CRF_PTR_X, CRF_AM_PREDEC, 6'h00};
    #20 chk("x after inc", opnd_w, 16'h0006);
    cyc();
    chk("predec addr", ds_addr, 16'h0005);
    ptr_req = '{CRF_PTR_X, CRF_AM_DISP, 6'h1f};
    cyc();
    chk("io hit", ds_is_io, 1);
    chk("io ds addr", ds_addr, 16'h0024);
    chk("io addr", io_addr, 6'h04);
    ptr_req = '{CRF_PTR_X, CRF_AM_PLAIN, 6'h00};
    ds_wr = 1;
    ds_wdata = 8'ha5;
    cyc();
    ds_wr = 0;
    ptr_req = '{CRF_PTR_Z, CRF_AM_PLAIN, 6'h00};
    rdchk(5'd5, 8'ha5);
    wr(PTR_Z_LO, 16'h1234, 1);
    req = '0;
    cyc();
    chk("flash addr", flash_lookup_addr, 16'h1234);
    {bit_store_instr, bit_reg, bit_pos} = {1'b1, 5'd5, 3'd0};
    cyc();
    {bit_store_instr, bit_load_instr, bit_reg, bit_pos} = {1'b0, 1'b1, 5'd6, 3'd3};
    cyc();
    bit_load_instr = 0;
    chk("copy bit", status_flags, 8'h40);
    rdchk(5'd6, 8'h08);
    irq_pending = 8'h0c;
    repeat (3) begin
      cyc();
      chk("no take", irq_take, 0);
    end
    irq_op = CRF_IE_SET;
    cyc();
    irq_op = CRF_IE_NONE;
    chk("enable set", status_flags, 8'hc0);
    cyc();
    chk("take", {irq_take, irq_vector}, 4'ha);
    chk("entry flags", status_flags, 8'h40);
    irq_pending = 8'h00;
    cyc();
    chk("pulse", irq_take, 0);
    irq_op = CRF_IE_RETURN;
    cyc();
    chk("return", status_flags, 8'hc0);
    irq_op = CRF_IE_CLEAR;
    irq_pending = 8'h01;
    cyc();
    irq_op = CRF_IE_NONE;
    chk("cli", {irq_take, status_flags}, 9'h040);
    cyc();
    chk("cli hold", irq_take, 0);
    irq_pending = 8'h00;
    sf_wr = 1;
    sf_wdata = 8'h1c;
    cyc();
    sf_wr = 0;
    chk("sw write", status_flags, 8'h0c);
    test_done();
  end
endmodule // test_cpu_register_file_status
